// file: core/smpp_pkg.sv
// Shared constants, frame layout and command codes for the serial
// memory programming port, used by the device end and the programmer end.
// Assumes both ends run their main logic from a 10 MHz clock.
package smpp_pkg;

  // ==========================================================================
  // Memory geometry
  localparam int FLASH_WORDS = 1024;
  localparam int FLASH_AW = 10;
  localparam int EE_BYTES = 128;
  localparam int EE_AW = 7;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // ==========================================================================
  // Frame layout: four bytes, first byte sent first, MSB first.
  localparam int FRAME_BITS = 32;
  localparam int BIT_CW = 5;
  localparam logic [4:0] FRAME_LAST = 5'h1f;
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [1:0] IDX_ADDR_LO = 2'h2;
  localparam logic [1:0] IDX_DATA = 2'h3;

  typedef struct packed {
    logic [7:0] op;
    logic [7:0] arg1;
    logic [7:0] arg2;
    logic [7:0] data;
  } smpp_frame_t;

  // ==========================================================================
  // Command codes.
  localparam logic [7:0] OP_ENABLE = 8'hac;
  localparam logic [7:0] ENABLE_SYNC = 8'h53;
  localparam logic [7:0] ERASE_ARG = 8'h80;
  localparam logic [7:0] OP_RD_FL_LO = 8'h20;
  localparam logic [7:0] OP_RD_FL_HI = 8'h28;
  localparam logic [7:0] OP_WR_FL_LO = 8'h40;
  localparam logic [7:0] OP_WR_FL_HI = 8'h48;
  localparam logic [7:0] OP_RD_EE = 8'ha0;
  localparam logic [7:0] OP_WR_EE = 8'hc0;

  // ==========================================================================
  // Timing, in printed units, and cycle counts derived from them.
  localparam int CLK_PERIOD_NS = 100;
  localparam int NS_PER_MS = 1000000;
  localparam int SETTLE_TIME_MS = 20;
  localparam int ERASE_WAIT_TIME_MS = 8;
  localparam int WRITE_WAIT_TIME_MS = 4;
  localparam int SCK_MIN_OSC = 2;
  localparam int RST_PULSE_OSC = 2;
  localparam int TIMER_W = 18;

  // A least time rounds up to whole cycles and is never below one.
  function automatic int cycles_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : cycles_min

  localparam int SETTLE_CYC = cycles_min(SETTLE_TIME_MS * NS_PER_MS);
  localparam int ERASE_WAIT_CYC = cycles_min(ERASE_WAIT_TIME_MS * NS_PER_MS);
  localparam int WRITE_WAIT_CYC = cycles_min(WRITE_WAIT_TIME_MS * NS_PER_MS);
  // Each clock phase must exceed two oscillator periods, hence one more.
  localparam int SCK_HALF_CYC = SCK_MIN_OSC + 1;
  localparam int RST_PULSE_CYC = RST_PULSE_OSC;

  // Commands that start a self-timed write cycle.
  function automatic logic is_write(input logic [7:0] op);
    return (op == OP_WR_FL_LO) || (op == OP_WR_FL_HI) || (op == OP_WR_EE);
  endfunction : is_write

  function automatic logic is_erase(input logic [7:0] op, input logic [7:0] arg1);
    return (op == OP_ENABLE) && (arg1 == ERASE_ARG);
  endfunction : is_erase

endpackage : smpp_pkg

// file: core/smpp_if.sv
// Serial programming link between the programmer and the device.
// The testbench resolves nothing here: miso is always driven, and miso_oe marks when it is valid.
`timescale 1ns/1ps
`default_nettype none
interface smpp_if;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic reset_n;

  // ==========================================================================
  // The programmer drives clock, data in and the device reset pin.
  modport prog (output sck, output mosi, output reset_n, input miso, input miso_oe);

  // The device drives data out and its enable.
  modport dev (input sck, input mosi, input reset_n, output miso, output miso_oe);
endinterface : smpp_if
`default_nettype wire

// file: core/smpp_dev.sv
// Device end of the serial programming port: link shifter on the serial
// clock, memory arrays, and a self-timed busy tracker on the main clock.
// Assumes the programmer holds the reset pin low during programming.
//
// Functional notes
// R1 - Program memories only while reset pin low.
// R2 - Ignore program and erase until enable command.
// R3 - EEPROM write auto-erases, self-timed cycle.
// R4 - Chip erase sets both arrays to ones.
// R5 - Flash words 0..0x3ff, EEPROM bytes 0..0x7f.
// R6 - Serial clock phases exceed two oscillator periods.
// R7 - Data in captured on serial clock rise.
// R8 - Data out shifted on serial clock fall.
// R9 - Commands are four-byte frames.
// R10 - Power-up with reset and clock low.
// R11 - Else clock low, pulse reset high.
// R12 - Wait 20 ms before enable command.
// R13 - Echo 0x53 when in sync.
// R14 - Programmer waits after chip erase.
// R15 - Programmer waits after each location write.
// R16 - Sample serial clock edges on main clock.
// R17 - Bytes travel most significant bit first.
`timescale 1ns/1ps
`default_nettype none
module smpp_dev #(
  parameter int ERASE_WAIT_CYC = smpp_pkg::ERASE_WAIT_CYC,
  parameter int WRITE_WAIT_CYC = smpp_pkg::WRITE_WAIT_CYC
) (
  // Main clock and reset
  input wire logic clock,
  input wire logic rst,
  // Serial link
  smpp_if.dev link,
  // Status towards the rest of the chip
  output logic busy,
  output logic prog_active,
  output logic sck_phase_err
);

  // ==========================================================================
  // Link domain state
  logic [smpp_pkg::BIT_CW-1:0] bit_cnt_r;
  logic [30:0] rx_r;
  logic [7:0] reply_r;
  logic enabled_r;
  logic evt_tgl_r;
  logic evt_erase_r;
  logic miso_r;
  logic miso_oe_r;
  logic [15:0] flash_r [smpp_pkg::FLASH_WORDS];
  logic [7:0] ee_r [smpp_pkg::EE_BYTES];

  // Decoding of the bits seen so far.
  wire [7:0] byte_in;
  wire [1:0] byte_idx;
  wire byte_end;
  wire frame_end;
  wire [23:0] head;
  wire [smpp_pkg::FLASH_AW-1:0] rd_faddr;
  wire [smpp_pkg::EE_AW-1:0] rd_eaddr;
  wire [7:0] rd_data;
  wire rd_hit;
  wire [7:0] reply_nxt;
  smpp_pkg::smpp_frame_t frame;
  wire [smpp_pkg::FLASH_AW-1:0] wr_faddr;
  wire [smpp_pkg::EE_AW-1:0] wr_eaddr;
  wire do_enable;
  wire do_erase;
  wire do_write;

  // The incoming bit completes the byte on the eighth rise, MSB first.
  assign byte_in = {rx_r[6:0], link.mosi}; // R17
  assign byte_idx = bit_cnt_r[4:3];
  assign byte_end = (bit_cnt_r[2:0] == smpp_pkg::BYTE_LAST);
  assign frame_end = (bit_cnt_r == smpp_pkg::FRAME_LAST); // R9
  assign head = {rx_r[22:0], link.mosi};
  assign frame = smpp_pkg::smpp_frame_t'({rx_r, link.mosi});

  // Read data is looked up as the address byte completes, so it is ready for
  // the very next falling edge; this is why the arrays live on the link clock.
  assign rd_faddr = {head[9:8], head[7:0]}; // R5
  assign rd_eaddr = head[6:0]; // R5
  assign rd_hit = enabled_r && ((head[23:16] == smpp_pkg::OP_RD_FL_LO) ||
                  (head[23:16] == smpp_pkg::OP_RD_FL_HI) || (head[23:16] == smpp_pkg::OP_RD_EE));
  assign rd_data = (head[23:16] == smpp_pkg::OP_RD_FL_LO) ? flash_r[rd_faddr][7:0] :
                   (head[23:16] == smpp_pkg::OP_RD_FL_HI) ? flash_r[rd_faddr][15:8] :
                   ee_r[rd_eaddr];

  // The reply to each of the first three bytes is the byte just received, or read data
  // after a read address byte, so the second byte of the enable command comes back during the third.
  assign reply_nxt = (byte_idx == smpp_pkg::IDX_DATA) ? 8'h00 :
                     ((byte_idx == smpp_pkg::IDX_ADDR_LO) && rd_hit) ? rd_data :
                     byte_in; // R13

  // Whole-frame command decode.
  assign wr_faddr = {frame.arg1[1:0], frame.arg2}; // R5
  assign wr_eaddr = frame.arg2[6:0]; // R5
  assign do_enable = frame_end && (frame.op == smpp_pkg::OP_ENABLE) &&
                     (frame.arg1 == smpp_pkg::ENABLE_SYNC); // R13
  assign do_erase = frame_end && enabled_r && smpp_pkg::is_erase(frame.op, frame.arg1); // R2
  assign do_write = frame_end && enabled_r && smpp_pkg::is_write(frame.op); // R2

  // ==========================================================================
  // Receive shifter and control. The reset pin high clears the link state at
  // once, because the serial clock is held still while it is high.
  always_ff @(posedge link.sck or posedge link.reset_n) begin
    if (link.reset_n) begin // R1
      bit_cnt_r <= '0;
      rx_r <= '0;
      reply_r <= '0;
      enabled_r <= 1'b0;
      evt_tgl_r <= 1'b0;
      evt_erase_r <= 1'b0;
    end else begin
      rx_r <= {rx_r[29:0], link.mosi}; // R7
      bit_cnt_r <= bit_cnt_r + 5'h01; // R9
      if (byte_end) begin
        reply_r <= reply_nxt;
      end
      if (do_enable) begin
        enabled_r <= 1'b1; // R2
      end
      if (do_erase || do_write) begin
        evt_tgl_r <= ~evt_tgl_r; // R3
        evt_erase_r <= do_erase;
      end
    end
  end

  // Memory arrays keep their contents across reset, as nonvolatile storage.
  // A write replaces the old byte outright, which stands for the auto-erase.
  always_ff @(posedge link.sck) begin
    if (do_erase) begin
      for (int i = 0; i < smpp_pkg::FLASH_WORDS; i++) begin
        flash_r[i] <= {smpp_pkg::ERASED_BYTE, smpp_pkg::ERASED_BYTE}; // R4
      end
      for (int j = 0; j < smpp_pkg::EE_BYTES; j++) begin
        ee_r[j] <= smpp_pkg::ERASED_BYTE; // R4
      end
    end else if (do_write) begin
      case (frame.op)
        smpp_pkg::OP_WR_FL_LO: flash_r[wr_faddr][7:0] <= frame.data;
        smpp_pkg::OP_WR_FL_HI: flash_r[wr_faddr][15:8] <= frame.data;
        default: ee_r[wr_eaddr] <= frame.data; // R3
      endcase
    end
  end

  // Transmit side: the reply byte leaves on falling edges, MSB first, so
  // each bit is stable across the following rise.
  always_ff @(negedge link.sck or posedge link.reset_n) begin
    if (link.reset_n) begin
      miso_r <= 1'b0;
      miso_oe_r <= 1'b0;
    end else begin
      miso_oe_r <= 1'b1;
      miso_r <= reply_r[~bit_cnt_r[2:0]]; // R8 R17
    end
  end

  assign link.miso = miso_r;
  assign link.miso_oe = miso_oe_r;

  // ==========================================================================
  // Main clock domain: synchronisers.
  logic sck_s1_r;
  logic sck_s2_r;
  logic sck_s3_r;
  logic rn_s1_r;
  logic rn_s2_r;
  logic en_s1_r;
  logic en_s2_r;
  logic ev_s1_r;
  logic ev_s2_r;
  logic ev_s3_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      sck_s1_r <= 1'b0;
      sck_s2_r <= 1'b0;
      sck_s3_r <= 1'b0;
      rn_s1_r <= 1'b1;
      rn_s2_r <= 1'b1;
      en_s1_r <= 1'b0;
      en_s2_r <= 1'b0;
      ev_s1_r <= 1'b0;
      ev_s2_r <= 1'b0;
      ev_s3_r <= 1'b0;
    end else begin
      sck_s1_r <= link.sck; // R16
      sck_s2_r <= sck_s1_r;
      sck_s3_r <= sck_s2_r;
      rn_s1_r <= link.reset_n;
      rn_s2_r <= rn_s1_r;
      en_s1_r <= enabled_r;
      en_s2_r <= en_s1_r;
      ev_s1_r <= evt_tgl_r;
      ev_s2_r <= ev_s1_r;
      ev_s3_r <= ev_s2_r;
    end
  end

  // ==========================================================================
  // Serial clock phase watch: a phase of two main clocks or less is flagged.
  // The flag is sticky until the device leaves programming mode.
  logic [3:0] phase_cnt_r;
  logic phase_err_r;
  wire sck_edge;
  wire phase_short;

  assign sck_edge = sck_s2_r ^ sck_s3_r; // R16
  assign phase_short = (phase_cnt_r < 4'(smpp_pkg::SCK_MIN_OSC)); // R6

  always_ff @(posedge clock) begin
    if (rst || rn_s2_r) begin
      phase_cnt_r <= '0;
      phase_err_r <= 1'b0;
    end else if (sck_edge) begin
      phase_cnt_r <= '0;
      phase_err_r <= phase_err_r | phase_short; // R6
    end else if (phase_cnt_r != 4'hf) begin
      phase_cnt_r <= phase_cnt_r + 4'h1;
    end
  end

  // ==========================================================================
  // Self-timed cycle: each write or erase event starts the busy timer. The
  // kind bit is stable long before the toggle arrives, so it is read directly.
  logic [smpp_pkg::TIMER_W-1:0] timer_r;
  logic busy_r;
  logic active_r;
  wire evt_pulse;

  assign evt_pulse = ev_s2_r ^ ev_s3_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      timer_r <= '0;
      busy_r <= 1'b0;
      active_r <= 1'b0;
    end else begin
      active_r <= en_s2_r && !rn_s2_r; // R1
      if (evt_pulse) begin
        timer_r <= evt_erase_r ? smpp_pkg::TIMER_W'(ERASE_WAIT_CYC - 1) :
                   smpp_pkg::TIMER_W'(WRITE_WAIT_CYC - 1); // R3
        busy_r <= 1'b1;
      end else if (timer_r != '0) begin
        timer_r <= timer_r - 1'b1;
      end else begin
        busy_r <= 1'b0;
      end
    end
  end

  assign busy = busy_r;
  assign prog_active = active_r;
  assign sck_phase_err = phase_err_r;

endmodule : smpp_dev
`default_nettype wire

// file: core/smpp_prog.sv
// Programmer end of the serial programming port: power-up sequence,
// enable with sync check, four-byte frames, and the waits after writes.
// Assumes the device reads data on rising and drives it on falling edges.
`timescale 1ns/1ps
`default_nettype none
module smpp_prog #(
  parameter int SETTLE_CYC = smpp_pkg::SETTLE_CYC,
  parameter int ERASE_WAIT_CYC = smpp_pkg::ERASE_WAIT_CYC,
  parameter int WRITE_WAIT_CYC = smpp_pkg::WRITE_WAIT_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Serial link
  smpp_if.prog link,
  // Command request
  input wire logic cmd_valid,
  input wire logic [31:0] cmd_word,
  output logic cmd_ready,
  // Response
  output logic rsp_valid,
  output logic [31:0] rsp_word,
  output logic in_sync
);

  typedef enum {S_POWER, S_PULSE, S_SETTLE, S_IDLE, S_SHIFT, S_WAIT} smpp_pst_t;

  // ==========================================================================
  // State
  smpp_pst_t state_r;
  logic [smpp_pkg::TIMER_W-1:0] timer_r;
  logic [1:0] div_r;
  logic [smpp_pkg::BIT_CW-1:0] bit_cnt_r;
  logic [31:0] tx_r;
  logic [31:0] rx_r;
  logic sck_r;
  logic mosi_r;
  logic reset_n_r;
  logic enable_frame_r;
  logic ready_r;
  logic rsp_valid_r;
  logic [31:0] rsp_r;
  logic sync_r;
  logic miso_s1_r;
  logic miso_s2_r;

  // Decoding of the finished frame and the divider.
  smpp_pkg::smpp_frame_t got;
  wire half_done;
  wire [smpp_pkg::TIMER_W-1:0] wait_cyc;
  wire need_wait;

  assign got = smpp_pkg::smpp_frame_t'(rx_r);
  assign half_done = (div_r == 2'(smpp_pkg::SCK_HALF_CYC - 1)); // R6
  assign need_wait = smpp_pkg::is_erase(cmd_word[31:24], cmd_word[23:16]) ||
                     smpp_pkg::is_write(cmd_word[31:24]);
  assign wait_cyc = smpp_pkg::is_erase(cmd_word[31:24], cmd_word[23:16]) ?
                    smpp_pkg::TIMER_W'(ERASE_WAIT_CYC - 1) : // R14
                    smpp_pkg::TIMER_W'(WRITE_WAIT_CYC - 1); // R15

  // ==========================================================================
  // Data out of the device is a pin: two flops before use.
  always_ff @(posedge clock) begin
    if (rst) begin
      miso_s1_r <= 1'b0;
      miso_s2_r <= 1'b0;
    end else begin
      miso_s1_r <= link.miso;
      miso_s2_r <= miso_s1_r;
    end
  end

  // ==========================================================================
  // Sequencer. The wait after a command is armed when the command is taken,
  // and counted only once its frame has finished.
  logic [smpp_pkg::TIMER_W-1:0] hold_r;
  logic hold_en_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= S_POWER;
      timer_r <= '0;
      div_r <= '0;
      bit_cnt_r <= '0;
      tx_r <= '0;
      rx_r <= '0;
      sck_r <= 1'b0;
      mosi_r <= 1'b0;
      reset_n_r <= 1'b0;
      enable_frame_r <= 1'b0;
      ready_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_r <= '0;
      sync_r <= 1'b0;
      hold_r <= '0;
      hold_en_r <= 1'b0;
    end else begin
      rsp_valid_r <= 1'b0;
      case (state_r)
        S_POWER: begin
          reset_n_r <= 1'b0; // R10
          sck_r <= 1'b0; // R10
          state_r <= S_PULSE;
          timer_r <= smpp_pkg::TIMER_W'(smpp_pkg::RST_PULSE_CYC - 1);
        end
        S_PULSE: begin
          reset_n_r <= 1'b1; // R11
          if (timer_r != '0) begin
            timer_r <= timer_r - 1'b1;
          end else begin
            state_r <= S_SETTLE;
            timer_r <= smpp_pkg::TIMER_W'(SETTLE_CYC - 1);
          end
        end
        S_SETTLE: begin
          reset_n_r <= 1'b0;
          if (timer_r != '0) begin
            timer_r <= timer_r - 1'b1; // R12
          end else begin
            state_r <= S_SHIFT;
            tx_r <= {smpp_pkg::OP_ENABLE, smpp_pkg::ENABLE_SYNC, 16'h0000}; // R2
            mosi_r <= smpp_pkg::OP_ENABLE[7];
            enable_frame_r <= 1'b1;
            hold_en_r <= 1'b0;
          end
        end
        S_IDLE: begin
          if (cmd_valid && ready_r) begin
            ready_r <= 1'b0;
            state_r <= S_SHIFT;
            tx_r <= cmd_word;
            mosi_r <= cmd_word[31]; // R17
            enable_frame_r <= 1'b0;
            hold_en_r <= need_wait;
            hold_r <= wait_cyc;
          end else begin
            ready_r <= 1'b1;
          end
        end
        S_SHIFT: begin
          div_r <= half_done ? 2'h0 : div_r + 2'h1;
          if (half_done && !sck_r) begin
            sck_r <= 1'b1;
            rx_r <= {rx_r[30:0], miso_s2_r}; // R7
          end else if (half_done) begin
            sck_r <= 1'b0;
            bit_cnt_r <= bit_cnt_r + 5'h01;
            mosi_r <= tx_r[30]; // R8
            tx_r <= {tx_r[30:0], 1'b0};
            if (bit_cnt_r == smpp_pkg::FRAME_LAST) begin // R9
              rsp_valid_r <= 1'b1;
              rsp_r <= rx_r;
              mosi_r <= 1'b0;
              if (enable_frame_r && (got.arg2 != smpp_pkg::ENABLE_SYNC)) begin
                state_r <= S_POWER; // R13
              end else if (hold_en_r) begin
                state_r <= S_WAIT;
                timer_r <= hold_r;
              end else begin
                state_r <= S_IDLE;
              end
              sync_r <= enable_frame_r ? (got.arg2 == smpp_pkg::ENABLE_SYNC) : sync_r;
            end
          end
        end
        S_WAIT: begin
          if (timer_r != '0) begin
            timer_r <= timer_r - 1'b1; // R14 R15
          end else begin
            state_r <= S_IDLE;
          end
        end
        default: state_r <= S_POWER;
      endcase
    end
  end

  assign link.sck = sck_r;
  assign link.mosi = mosi_r;
  assign link.reset_n = reset_n_r;
  assign cmd_ready = ready_r;
  assign rsp_valid = rsp_valid_r;
  assign rsp_word = rsp_r;
  assign in_sync = sync_r;

endmodule : smpp_prog
`default_nettype wire

// file: test/smpp_chk.sv
// Checker for the serial link between the programmer end and the device end.
// Assumes it sees the link signals of one interface and the main clock domain.
`timescale 1ns/1ps
`default_nettype none
module smpp_chk #(
  parameter int SETTLE_CYC = 50
) (
  // Main clock and reset
  input wire logic clock,
  input wire logic rst,
  // Link signals
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic reset_n
);
  // ==========================================================================
  // Helper logic
  logic sck_d_r;
  logic done_r;
  logic [4:0] bits_r;
  logic [31:0] mo_r;
  logic [31:0] mi_r;
  logic [31:0] settle_r;
  wire sck_rise = sck & ~sck_d_r;
  wire [31:0] settle_nxt = (settle_r == 32'hffffffff) ? settle_r : settle_r + 32'h1;
  wire miso_seen = miso & miso_oe;

  // Bits are gathered at each rise; an undriven data-out line counts as zero.
  always_ff @(posedge clock) begin
    sck_d_r <= sck;
    done_r <= sck_rise && (bits_r == 5'h1f);
    bits_r <= (rst || reset_n) ? 5'h0 : bits_r + {4'h0, sck_rise};
    settle_r <= (rst || reset_n) ? 32'h0 : settle_nxt;
  end

  // Shift registers hold the last frame in both directions.
  always_ff @(posedge clock) begin
    if (sck_rise) begin
      mo_r <= {mo_r[30:0], mosi};
      mi_r <= {mi_r[30:0], miso_seen};
    end
  end

  // ==========================================================================
  // Properties
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_mosi_held;
    $stable(mosi) ##1 $stable(mosi) ##1 $stable(mosi);
  endsequence

  property p_sck_idle; reset_n |-> !sck; endproperty
  property p_rst_pulse; $rose(reset_n) |-> reset_n [*2]; endproperty
  property p_settle; $rose(sck) |-> settle_r >= SETTLE_CYC; endproperty
  property p_sck_high; $rose(sck) |=> sck [*2]; endproperty
  property p_sck_low; $fell(sck) |=> !sck [*2]; endproperty
  property p_mosi_hold; $rose(sck) |-> s_mosi_held; endproperty
  property p_miso_fall; !reset_n && $changed(miso) |-> $fell(sck); endproperty
  property p_oe_reset; miso_oe |-> !reset_n; endproperty
  property p_sync_echo;
    done_r && (mo_r[31:16] == {smpp_pkg::OP_ENABLE, smpp_pkg::ENABLE_SYNC}) |-> mi_r[15:8] == smpp_pkg::ENABLE_SYNC;
  endproperty

  a_sck_idle: assert property (p_sck_idle)
    else $error("sck high while reset pin high");
  a_rst_pulse: assert property (p_rst_pulse)
    else $error("reset pin pulse too short");
  a_settle: assert property (p_settle)
    else $error("sck started before the settle time");
  a_sck_high: assert property (p_sck_high)
    else $error("sck high phase too short");
  a_sck_low: assert property (p_sck_low)
    else $error("sck low phase too short");
  a_mosi_hold: assert property (p_mosi_hold)
    else $error("mosi moved around the sck rise");
  a_miso_fall: assert property (p_miso_fall)
    else $error("miso moved away from an sck fall");
  a_oe_reset: assert property (p_oe_reset)
    else $error("miso driven while reset pin high");
  a_sync_echo: assert property (p_sync_echo)
    else $error("sync byte not echoed");
endmodule : smpp_chk
`default_nettype wire

// file: test/smpp_tb.sv
// Testbench joining the programmer end to the device end over one link.
// Assumes the programmer makes the serial clock; a second device sees bad clocks.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module smpp_tb;
  // ==========================================================================
  // Signals
  localparam int SETTLE = 50;
  localparam int ERASE = 40;
  localparam int WRITE = 20;
  localparam int LIMIT = 20000;
  logic clock, rst, cmd_valid, cmd_ready, rsp_valid, in_sync;
  logic busy, prog_active, sck_phase_err, flt_err, busy_seen;
  logic [31:0] cmd_word, rsp_word, r;
  int bad_count, comparisons, cycles, n;
  // Erase, reads after erase, writes to the top and bottom addresses, read back,
  // then an EEPROM rewrite with no erase between, which must still land whole.
  logic [31:0] cmds [13] = '{32'hac800000, 32'h2003ff00, 32'ha0007f00, 32'hc0007f5a, 32'h4803ffa5,
    32'h4000003c, 32'ha0007f00, 32'h2803ff00, 32'h20000000, 32'h2003ff00, 32'ha0000000,
    32'hc0007fc3, 32'ha0007f00};
  // Bit 8 marks a read whose last byte is compared.
  logic [8:0] exps [13] = '{9'h0, 9'h1ff, 9'h1ff, 9'h0, 9'h0, 9'h0, 9'h15a, 9'h1a5, 9'h13c, 9'h1ff, 9'h1ff,
    9'h0, 9'h1c3};

  // ==========================================================================
  // Design, checker and the faulty-link device
  smpp_if link_if();
  smpp_if flt_if();
  smpp_dev #(.ERASE_WAIT_CYC(ERASE), .WRITE_WAIT_CYC(WRITE)) smpp_dev_i (.clock(clock), .rst(rst),
    .link(link_if.dev), .busy(busy), .prog_active(prog_active), .sck_phase_err(sck_phase_err));
  smpp_prog #(.SETTLE_CYC(SETTLE), .ERASE_WAIT_CYC(ERASE), .WRITE_WAIT_CYC(WRITE)) smpp_prog_i (
    .clock(clock), .rst(rst), .link(link_if.prog), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_word(rsp_word), .in_sync(in_sync));
  smpp_chk #(.SETTLE_CYC(SETTLE)) smpp_chk_i (.clock(clock), .rst(rst), .sck(link_if.sck),
    .mosi(link_if.mosi), .miso(link_if.miso), .miso_oe(link_if.miso_oe), .reset_n(link_if.reset_n));
  smpp_dev smpp_dev_flt_i (.clock(clock), .rst(rst), .link(flt_if.dev), .busy(), .prog_active(),
    .sck_phase_err(flt_err));

  // ==========================================================================
  // Clock, hang guard and busy watch
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // A hang counts as a mismatch and still ends in the report.
  always @(posedge clock) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      summarize();
    end
  end
  always @(negedge clock) if (busy === 1'b1) busy_seen = 1'b1;

  // ==========================================================================
  // Tasks
  task automatic summarize();
    $display("counts: %0d compared, %0d wrong", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize

  task automatic wait_ready();
    n = 0;
    while (cmd_ready !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    `CHK(cmd_ready, 1'b1)
  endtask : wait_ready

  // Hands one frame to the programmer and takes its reply word.
  task automatic xfer(input logic [31:0] w, output logic [31:0] rw);
    wait_ready();
    @(posedge clock);
    #1 cmd_valid = 1'b1;
    cmd_word = w;
    @(posedge clock);
    #1 cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 1000) begin
      @(negedge clock);
      n++;
    end
    `CHK(rsp_valid, 1'b1)
    rw = rsp_word;
  endtask : xfer

  // ==========================================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_word = 32'h0;
    flt_if.sck = 1'b0;
    flt_if.mosi = 1'b0;
    flt_if.reset_n = 1'b1;
    busy_seen = 1'b0;
    bad_count = 0;
    comparisons = 0;
    cycles = 0;
    repeat (4) @(posedge clock);
    #1 rst = 1'b0;
    repeat (3) @(negedge clock);
    `CHK(prog_active, 1'b0)
    wait_ready();
    `CHK(in_sync, 1'b1)
    `CHK(prog_active, 1'b1)
    $display("test sync done");
    for (int i = 0; i < 13; i++) begin
      xfer(cmds[i], r);
      `CHK(r[23:8], cmds[i][31:16])
      if (exps[i][8]) `CHK(r[7:0], exps[i][7:0])
    end
    // The rewrite turns zeros to ones and ones to zeros, so it lands whole only through the auto-erase.
    `CHK(r[7:0], 8'hc3)
    `CHK(busy_seen, 1'b1)
    `CHK(sck_phase_err, 1'b0)
    $display("test memory done");
    // Phases of one clock on the second link must be flagged.
    @(posedge clock);
    #1 flt_if.reset_n = 1'b0;
    repeat (10) begin
      @(posedge clock);
      #1 flt_if.sck = ~flt_if.sck;
    end
    repeat (4) @(negedge clock);
    `CHK(flt_err, 1'b1)
    $display("test phase fault done");
    summarize();
  end
endmodule : smpp_tb
`default_nettype wire
